// ### design/queue_remover_pkg.sv
package queue_remover_pkg;
   // ==========================================
   // Operation select codes
   localparam logic [2:0] OP_TAIL_RQ = 3'h0;  // remove_tail_interlocked_resident_quad
   localparam logic [2:0] OP_ABS_L   = 3'h1;  // remove_absolute_long
   localparam logic [2:0] OP_ABS_LD  = 3'h2;  // remove_absolute_long_deferred
   localparam logic [2:0] OP_ABS_Q   = 3'h3;  // remove_absolute_quad
   localparam logic [2:0] OP_ABS_QD  = 3'h4;  // remove_absolute_quad_deferred
   // ==========================================
   // Memory commands
   localparam logic [2:0] CMD_READ   = 3'h0;
   localparam logic [2:0] CMD_WRITE  = 3'h1;
   localparam logic [2:0] CMD_LOCKLD = 3'h2;
   localparam logic [2:0] CMD_CONDST = 3'h3;
   localparam logic [2:0] CMD_BAR    = 3'h4;  // memory_barrier
   localparam logic [2:0] CMD_PROBE  = 3'h5;  // Write permission check, no store
   // ==========================================
   // Fault and exception codes
   localparam logic [2:0] EXC_NONE = 3'h0;
   localparam logic [2:0] EXC_ACV  = 3'h1;
   localparam logic [2:0] EXC_FOR  = 3'h2;
   localparam logic [2:0] EXC_FOW  = 3'h3;
   localparam logic [2:0] EXC_TNV  = 3'h4;
   localparam logic [2:0] EXC_ILL  = 3'h5;
   // ==========================================
   // Queue layout and status values
   localparam logic [63:0] LINK_OFS_L = 64'h4;
   localparam logic [63:0] LINK_OFS_Q = 64'h8;
   localparam logic [63:0] ST_FAIL    = 64'hffff_ffff_ffff_ffff;
   localparam logic [63:0] ST_ZERO    = 64'h0;
   localparam logic [63:0] ST_ONE     = 64'h1;
   localparam logic [63:0] ST_TWO     = 64'h2;
   localparam int          QALIGN_W   = 4;
   // ==========================================
   // Register map
   localparam logic [3:0] REG_EVT   = 4'h0;
   localparam logic [3:0] REG_MASK  = 4'h4;
   localparam logic [3:0] REG_RETRY = 4'h8;
   localparam logic [3:0] REG_STATE = 4'hc;
   localparam int         EVT_DONE  = 0;
   localparam int         EVT_EXC   = 1;
   localparam int         EVT_BUSYQ = 2;
   localparam int         EVT_W     = 3;
   localparam logic [7:0] RETRY_RST = 8'h10;
endpackage

// ### design/queue_remover_regs.sv
`timescale 1ns/10ps
`default_nettype none
module queue_remover_regs
   import queue_remover_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // Events and state from the sequencer
   input  wire logic [queue_remover_pkg::EVT_W-1:0] evt_in,
   input  wire logic [15:0] state_view,
   // Configuration and interrupt
   output logic      [7:0]  retry_limit,
   output logic             irq
);
   import queue_remover_pkg::*;

   logic [EVT_W-1:0] evt;
   logic [EVT_W-1:0] mask;

   // ==========================================
   // Sticky events, write one to clear, set wins
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         evt <= '0;
      end else if (reg_wr && reg_addr == REG_EVT) begin
         evt <= (evt & ~reg_wdata[EVT_W-1:0]) | evt_in;
      end else begin
         evt <= evt | evt_in;
      end
   end

   // Mask and retry configuration
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mask        <= '0;
         retry_limit <= RETRY_RST;
      end else if (reg_wr) begin
         if (reg_addr == REG_MASK) mask <= reg_wdata[EVT_W-1:0];
         if (reg_addr == REG_RETRY) retry_limit <= reg_wdata[7:0];
      end
   end

   // Read data one cycle after the strobe, unmapped reads zero
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= '0;
         if (reg_rd) begin
            case (reg_addr)
               REG_EVT:   reg_rdata <= {{(32-EVT_W){1'b0}}, evt};
               REG_MASK:  reg_rdata <= {{(32-EVT_W){1'b0}}, mask};
               REG_RETRY: reg_rdata <= {24'h0, retry_limit};
               REG_STATE: reg_rdata <= {16'h0, state_view};
               default:   reg_rdata <= '0;
            endcase
         end
      end
   end

   // Level interrupt from unmasked events
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) irq <= 1'b0;
      else irq <= |((evt | evt_in) & mask);
   end
endmodule
`default_nettype wire

// ### design/queue_entry_remover.sv
`timescale 1ns/10ps
`default_nettype none
module queue_entry_remover
   import queue_remover_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // Operation request
   input  wire logic        op_start,
   input  wire logic [2:0]  op_sel,
   input  wire logic [63:0] operand_address_reg,
   // Operation result
   output logic             done,
   output logic             busy,
   output logic      [63:0] status_result_reg,
   output logic      [63:0] removed_entry_reg,
   output logic      [2:0]  exc_code,
   // Memory port
   output logic             mem_req,
   output logic      [2:0]  mem_cmd,
   output logic             mem_quad,
   output logic      [63:0] mem_addr,
   output logic      [63:0] mem_wdata,
   output logic             mem_lock,
   input  wire logic        mem_ack,
   input  wire logic [63:0] mem_rdata,
   input  wire logic        mem_sc_ok,
   input  wire logic [2:0]  mem_fault,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   output logic             irq
);
   import queue_remover_pkg::*;

   typedef enum logic [4:0] {
      S_IDLE = 5'h00, S_PTR  = 5'h01, S_LL   = 5'h02, S_SC   = 5'h03,
      S_MB1  = 5'h04, S_HBL  = 5'h05, S_EBL  = 5'h06, S_WHBL = 5'h07,
      S_WPFL = 5'h08, S_MB2  = 5'h09, S_WHFL = 5'h0a, S_AFL  = 5'h0b,
      S_ABL  = 5'h0c, S_PRB1 = 5'h0d, S_PRB2 = 5'h0e, S_AW1  = 5'h0f,
      S_AW2  = 5'h10, S_FIN  = 5'h11
   } state_t;

   state_t      state;
   state_t      next_state;
   logic [2:0]  op;
   logic        quad;
   logic [63:0] hdr, tmp0, entry, pred, efl, ebl;
   logic [63:0] st_val;
   logic [2:0]  ex_val;
   logic [7:0]  retry_cnt;
   logic [7:0]  retry_limit;
   logic        pend;
   logic [2:0]  next_cmd;
   logic [63:0] next_addr, next_wdata;
   logic [EVT_W-1:0] evt_in;
   logic        ack_ok;
   logic [63:0] link_ofs;
   logic [63:0] rd_link;

   // ==========================================
   // Helpers
   function automatic logic is_mem_state(input state_t s);
      is_mem_state = !(s == S_IDLE || s == S_FIN);
   endfunction

   function automatic logic [63:0] sx32(input logic [63:0] v);
      sx32 = {{32{v[31]}}, v[31:0]};
   endfunction

   function automatic logic misq(input logic [63:0] v);
      misq = v[QALIGN_W-1:0] != '0;
   endfunction

   assign ack_ok   = mem_ack && mem_fault == EXC_NONE;
   assign link_ofs = quad ? LINK_OFS_Q : LINK_OFS_L;
   assign rd_link  = quad ? mem_rdata : sx32(mem_rdata);

   // ==========================================
   // Next state
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (op_start) begin
               case (op_sel)
                  OP_TAIL_RQ:                     next_state = S_LL;
                  OP_ABS_L:                       next_state = S_AFL;
                  OP_ABS_LD:                      next_state = S_PTR;
                  OP_ABS_Q:
                     next_state = misq(operand_address_reg) ? S_FIN : S_AFL;
                  OP_ABS_QD:
                     next_state = misq(operand_address_reg) ? S_FIN : S_PTR;
                  default:                        next_state = S_FIN;
               endcase
            end
         end
         S_FIN: next_state = S_IDLE;
         default: begin
            if (mem_ack && mem_fault != EXC_NONE) begin
               next_state = S_FIN;
            end else if (mem_ack) begin
               case (state)
                  S_PTR:  next_state = (quad && misq(mem_rdata)) ? S_FIN : S_AFL;
                  S_LL:   next_state = mem_rdata[0] ? S_FIN : S_SC;
                  S_SC:   next_state = mem_sc_ok ? S_MB1 :
                                       (retry_cnt <= 8'h1) ? S_FIN : S_LL;
                  S_MB1:  next_state = S_HBL;
                  S_HBL:  next_state = S_EBL;
                  S_EBL:  next_state = S_WHBL;
                  S_WHBL: next_state = (pred == hdr) ? S_WHFL : S_WPFL;
                  S_WPFL: next_state = S_MB2;
                  S_MB2:  next_state = S_WHFL;
                  S_WHFL: next_state = S_FIN;
                  S_AFL:  next_state = (quad && misq(mem_rdata)) ? S_FIN : S_ABL;
                  S_ABL:  next_state = (quad && misq(mem_rdata)) ? S_FIN : S_PRB1;
                  S_PRB1: next_state = S_PRB2;
                  S_PRB2: next_state = S_AW1;
                  S_AW1:  next_state = S_AW2;
                  S_AW2:  next_state = S_FIN;
                  default: next_state = S_FIN;
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) state <= S_IDLE;
      else state <= next_state;
   end

   // ==========================================
   // Memory request contents for each step
   always_comb begin
      next_cmd   = CMD_READ;
      next_addr  = '0;
      next_wdata = '0;
      case (state)
         S_PTR:  next_addr = hdr;
         S_LL: begin
            next_cmd  = CMD_LOCKLD;
            next_addr = hdr;
         end
         S_SC: begin
            next_cmd   = CMD_CONDST;
            next_addr  = hdr;
            next_wdata = tmp0 | 64'h1;
         end
         S_MB1, S_MB2: next_cmd = CMD_BAR;
         S_HBL:  next_addr = hdr + LINK_OFS_Q;
         S_EBL:  next_addr = entry + LINK_OFS_Q;
         S_WHBL: begin
            next_cmd   = CMD_WRITE;
            next_addr  = hdr + LINK_OFS_Q;
            next_wdata = pred - hdr;
         end
         S_WPFL: begin
            next_cmd   = CMD_WRITE;
            next_addr  = pred;
            next_wdata = hdr - pred;
         end
         S_WHFL: begin
            next_cmd   = CMD_WRITE;
            next_addr  = hdr;
            next_wdata = (pred == hdr) ? 64'h0 : tmp0;
         end
         S_AFL:  next_addr = entry;
         S_ABL:  next_addr = entry + link_ofs;
         S_PRB1: begin
            next_cmd  = CMD_PROBE;
            next_addr = ebl;
         end
         S_PRB2: begin
            next_cmd  = CMD_PROBE;
            next_addr = efl + link_ofs;
         end
         S_AW1: begin
            next_cmd   = CMD_WRITE;
            next_addr  = ebl;
            next_wdata = efl;
         end
         S_AW2: begin
            next_cmd   = CMD_WRITE;
            next_addr  = efl + link_ofs;
            next_wdata = ebl;
         end
         default: next_cmd = CMD_READ;
      endcase
   end

   // One request per step, then wait for its answer
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mem_req   <= 1'b0;
         pend      <= 1'b0;
         mem_cmd   <= CMD_READ;
         mem_quad  <= 1'b0;
         mem_addr  <= '0;
         mem_wdata <= '0;
      end else begin
         mem_req <= 1'b0;
         if (mem_ack) begin
            pend <= 1'b0;
         end else if (!pend && is_mem_state(state)) begin
            mem_req   <= 1'b1;
            pend      <= 1'b1;
            mem_cmd   <= next_cmd;
            mem_quad  <= quad;
            mem_addr  <= next_addr;
            mem_wdata <= next_wdata;
         end
      end
   end

   // Bus lock held from start until entry to S_FIN, a cycle before done, keeps the removal atomic
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) mem_lock <= 1'b0;
      else mem_lock <= (next_state != S_IDLE) && (next_state != S_FIN);
   end

   // ==========================================
   // Operand capture and link values
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         op        <= OP_TAIL_RQ;
         quad      <= 1'b0;
         hdr       <= '0;
         tmp0      <= '0;
         entry     <= '0;
         pred      <= '0;
         efl       <= '0;
         ebl       <= '0;
         retry_cnt <= '0;
      end else if (state == S_IDLE && op_start) begin
         op        <= op_sel;
         quad      <= op_sel != OP_ABS_L && op_sel != OP_ABS_LD;
         hdr       <= operand_address_reg;
         retry_cnt <= (retry_limit == 8'h0) ? 8'h1 : retry_limit;
         entry     <= (op_sel == OP_ABS_L) ? sx32(operand_address_reg)
                                           : operand_address_reg;
      end else if (ack_ok) begin
         case (state)
            S_PTR: entry <= rd_link;
            S_LL:  tmp0 <= mem_rdata;
            S_SC:  retry_cnt <= retry_cnt - 8'h1;
            S_HBL: entry <= hdr + mem_rdata;
            S_EBL: pred <= entry + mem_rdata;
            S_AFL: efl <= rd_link;
            S_ABL: ebl <= rd_link;
            default: tmp0 <= tmp0;
         endcase
      end
   end

   // ==========================================
   // Status and exception accumulation
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_val <= ST_ZERO;
         ex_val <= EXC_NONE;
      end else if (state == S_IDLE && op_start) begin
         st_val <= ST_ZERO;
         ex_val <= EXC_NONE;
         if (op_sel > OP_ABS_QD) ex_val <= EXC_ILL;
         else if ((op_sel == OP_ABS_Q || op_sel == OP_ABS_QD)
                  && misq(operand_address_reg)) ex_val <= EXC_ILL;
      end else if (mem_ack && mem_fault != EXC_NONE) begin
         ex_val <= mem_fault;
      end else if (mem_ack) begin
         case (state)
            S_PTR: if (quad && misq(mem_rdata)) ex_val <= EXC_ILL;
            S_AFL: if (quad && misq(mem_rdata)) ex_val <= EXC_ILL;
            S_ABL: if (quad && misq(mem_rdata)) ex_val <= EXC_ILL;
            S_LL:  if (mem_rdata[0]) st_val <= ST_FAIL;
            S_SC:  if (!mem_sc_ok && retry_cnt <= 8'h1) st_val <= ST_FAIL;
            S_WHFL:
               st_val <= (tmp0 == 64'h0) ? ST_ZERO :
                         (pred == hdr) ? ST_TWO : ST_ONE;
            S_AW2:
               st_val <= (ebl == entry) ? ST_FAIL :
                         (efl == ebl) ? ST_ZERO : ST_ONE;
            default: st_val <= st_val;
         endcase
      end
   end

   // Results presented with the done pulse
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         done              <= 1'b0;
         busy              <= 1'b0;
         status_result_reg <= '0;
         removed_entry_reg <= '0;
         exc_code          <= EXC_NONE;
      end else begin
         done <= state == S_FIN;
         busy <= next_state != S_IDLE;
         if (state == S_FIN) begin
            status_result_reg <= st_val;
            removed_entry_reg <= entry;
            exc_code          <= ex_val;
         end
      end
   end

   // ==========================================
   // Registers and interrupt
   assign evt_in = {state == S_FIN && st_val == ST_FAIL && op == OP_TAIL_RQ,
                    state == S_FIN && ex_val != EXC_NONE,
                    state == S_FIN};

   queue_remover_regs u_regs (
      .mclk        (mclk),
      .rstn        (rstn),
      .reg_addr    (reg_addr),
      .reg_wdata   (reg_wdata),
      .reg_wr      (reg_wr),
      .reg_rd      (reg_rd),
      .reg_rdata   (reg_rdata),
      .evt_in      (evt_in),
      .state_view  ({3'h0, state, retry_cnt}),
      .retry_limit (retry_limit),
      .irq         (irq)
   );

   // ==========================================
   // Assertions
   property p_lock_set;
      @(posedge mclk) disable iff (!rstn)
      (state == S_LL && ack_ok && mem_rdata[0])
         |-> ##2 (done && status_result_reg == ST_FAIL);
   endproperty
   a_lock_set: assert property (p_lock_set) else $error("interlock set not -1");

   property p_retry_out;
      @(posedge mclk) disable iff (!rstn)
      (state == S_SC && ack_ok && !mem_sc_ok && retry_cnt == 8'h1)
         |-> ##2 (done && status_result_reg == ST_FAIL);
   endproperty
   a_retry_out: assert property (p_retry_out) else $error("retry end not -1");

   property p_hdr_bl;
      @(posedge mclk) disable iff (!rstn)
      (mem_req && state == S_HBL) |-> (mem_addr == hdr + LINK_OFS_Q)
         && $past(state == S_MB1, 2);
   endproperty
   a_hdr_bl: assert property (p_hdr_bl) else $error("header link read wrong");

   property p_hdr_wr;
      @(posedge mclk) disable iff (!rstn)
      (mem_req && state == S_WHBL) |-> mem_wdata == pred - hdr;
   endproperty
   a_hdr_wr: assert property (p_hdr_wr) else $error("header backward link wrong");

   property p_release;
      @(posedge mclk) disable iff (!rstn)
      (state == S_WPFL && ack_ok) |=> state == S_MB2 ##1 state == S_MB2;
   endproperty
   a_release: assert property (p_release) else $error("no barrier before release");

   property p_tail_st;
      @(posedge mclk) disable iff (!rstn)
      (state == S_WHFL && ack_ok && tmp0 != 64'h0 && pred == hdr)
         |-> ##2 (status_result_reg == ST_TWO && removed_entry_reg == entry);
   endproperty
   a_tail_st: assert property (p_tail_st) else $error("tail status not 2");

   property p_lock_held;
      @(posedge mclk) disable iff (!rstn)
      mem_req |-> mem_lock;
   endproperty
   a_lock_held: assert property (p_lock_held) else $error("access without lock");

   property p_abs_st;
      @(posedge mclk) disable iff (!rstn)
      (state == S_AW2 && ack_ok && ebl == entry) |-> ##2 status_result_reg == ST_FAIL;
   endproperty
   a_abs_st: assert property (p_abs_st) else $error("empty queue not -1");

   property p_no_store;
      @(posedge mclk) disable iff (!rstn)
      (state inside {S_PRB1, S_PRB2} && mem_ack && mem_fault != EXC_NONE)
         |=> state == S_FIN;
   endproperty
   a_no_store: assert property (p_no_store) else $error("store after fault");

   property p_misalign;
      @(posedge mclk) disable iff (!rstn)
      (state == S_AFL && ack_ok && quad && mem_rdata[3:0] != 4'h0)
         |-> ##2 (done && exc_code == EXC_ILL);
   endproperty
   a_misalign: assert property (p_misalign) else $error("misaligned link accepted");

   property p_one_op;
      @(posedge mclk) disable iff (!rstn)
      done |=> !busy || $past(op_start);
   endproperty
   a_one_op: assert property (p_one_op) else $error("busy after done");

   c_tail_ok: cover property (@(posedge mclk) disable iff (!rstn)
      done && status_result_reg == ST_ONE && exc_code == EXC_NONE);
   c_abs_empty: cover property (@(posedge mclk) disable iff (!rstn)
      state == S_AW2 && ack_ok && efl == ebl);
   c_retry: cover property (@(posedge mclk) disable iff (!rstn)
      state == S_SC && mem_ack && !mem_sc_ok);
   c_fault: cover property (@(posedge mclk) disable iff (!rstn)
      done && exc_code != EXC_NONE);
endmodule
`default_nettype wire

// ### tb/queue_memory_model.sv
`timescale 1ns/10ps
`default_nettype none
module queue_memory_model
   import queue_remover_pkg::*;
(
   // Clock
   input  wire logic        mclk,
   // Memory port
   input  wire logic        mem_req,
   input  wire logic [2:0]  mem_cmd,
   input  wire logic        mem_quad,
   input  wire logic [63:0] mem_addr,
   input  wire logic [63:0] mem_wdata,
   output logic             mem_ack,
   output logic      [63:0] mem_rdata,
   output logic             mem_sc_ok,
   output logic      [2:0]  mem_fault,
   // Test controls
   input  wire logic [3:0]  delay,
   input  wire logic        sc_fail,
   input  wire logic [63:0] fault_addr,
   input  wire logic [2:0]  fault_code
);
   logic [63:0] mem [logic [63:0]];
   logic [2:0]  f;
   // Serve one request at a time, one answer each, after the chosen delay
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 64'h5a5a_5a5a_5a5a_5a5a;
      mem_sc_ok = 1'b0;
      mem_fault = 3'h0;
      forever begin
         @(posedge mclk);
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;  // Idle data inverts each cycle, but holds its value while a request's delay runs
         if (mem_req === 1'b1) begin
            repeat (delay) @(posedge mclk);
            f = (mem_addr == fault_addr && mem_cmd != CMD_BAR) ? fault_code : 3'h0;
            mem_ack <= 1'b1;
            mem_fault <= f;
            mem_sc_ok <= !sc_fail;
            if (f == 3'h0 && (mem_cmd == CMD_READ || mem_cmd == CMD_LOCKLD))
               mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 64'h0;
            if (f == 3'h0 && (mem_cmd == CMD_WRITE || (mem_cmd == CMD_CONDST && !sc_fail)))
               mem[mem_addr] = mem_quad ? mem_wdata : {32'h0, mem_wdata[31:0]};
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/test_queue_entry_remover.sv
`timescale 1ns/10ps
`default_nettype none
module test_queue_entry_remover;
   import queue_remover_pkg::*;
   // ==========================================
   // Signals
   logic        mclk, rstn, op_start, done, busy, irq, mem_req, mem_quad, mem_lock;
   logic        mem_ack, mem_sc_ok, sc_fail, reg_wr, reg_rd;
   logic [2:0]  op_sel, exc_code, mem_cmd, mem_fault, fault_code;
   logic [3:0]  reg_addr, delay;
   logic [31:0] reg_wdata, reg_rdata;
   logic [63:0] opnd, status, entry, mem_addr, mem_wdata, mem_rdata, fault_addr;
   int          mismatches, checks;
   // ==========================================
   // Design and memory model
   queue_entry_remover u_dut (.mclk, .rstn, .op_start, .op_sel,
      .operand_address_reg(opnd), .done, .busy, .status_result_reg(status),
      .removed_entry_reg(entry), .exc_code, .mem_req, .mem_cmd, .mem_quad, .mem_addr,
      .mem_wdata, .mem_lock, .mem_ack, .mem_rdata, .mem_sc_ok, .mem_fault, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
   queue_memory_model u_mem (.mclk, .mem_req, .mem_cmd, .mem_quad, .mem_addr, .mem_wdata,
      .mem_ack, .mem_rdata, .mem_sc_ok, .mem_fault, .delay, .sc_fail, .fault_addr,
      .fault_code);
   // Clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // ==========================================
   // Tasks
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [63:0] m(input logic [63:0] a);
      return u_mem.mem[a];
   endfunction
   task automatic run(input logic [2:0] sel, input logic [63:0] a);
      int n;
      n = 0;
      @(posedge mclk);
      op_sel <= sel;
      opnd <= a;
      op_start <= 1'b1;
      @(posedge mclk);
      op_start <= 1'b0;
      while (done !== 1'b1 && n < 3000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk({63'h0, done}, 64'h1);
      $display("test with select %0d finished", sel);
   endtask
   task automatic rr(input logic [3:0] a, input logic [31:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk({32'h0, reg_rdata}, {32'h0, exp});
   endtask
   task automatic rw(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic report_and_stop;
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      report_and_stop;
   end
   // ==========================================
   // Main sequence
   initial begin
      {rstn, op_start, op_sel, opnd, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {sc_fail, fault_code, delay, mismatches, checks} = '0;
      fault_addr = '1;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      rr(REG_RETRY, 32'h10);
      rr(4'h1, 32'h0);
      // Self-relative quad queue with two aligned entries
      u_mem.mem[64'h3000] = 64'h40;
      u_mem.mem[64'h3008] = 64'h80;
      u_mem.mem[64'h3040] = 64'h40;
      u_mem.mem[64'h3048] = 64'hffff_ffff_ffff_ffc0;
      u_mem.mem[64'h3080] = 64'hffff_ffff_ffff_ff80;
      u_mem.mem[64'h3088] = 64'hffff_ffff_ffff_ffc0;
      delay <= 4'h2;
      run(OP_TAIL_RQ, 64'h3000);
      chk(status, ST_ONE);
      chk(entry, 64'h3080);
      chk(m(64'h3008), 64'h40);
      chk(m(64'h3040), 64'hffff_ffff_ffff_ffc0);
      chk(m(64'h3000), 64'h40);
      run(OP_TAIL_RQ, 64'h3000);
      chk(status, ST_TWO);
      chk(entry, 64'h3040);
      chk(m(64'h3000), 64'h0);
      run(OP_TAIL_RQ, 64'h3000);
      chk(status, ST_ZERO);
      u_mem.mem[64'h3000] = 64'h1;
      run(OP_TAIL_RQ, 64'h3000);
      chk(status, ST_FAIL);
      chk(m(64'h3000), 64'h1);
      u_mem.mem[64'h3000] = 64'h0;
      rw(REG_RETRY, 32'h2);
      rw(REG_MASK, 32'h4);
      rr(REG_MASK, 32'h4);
      sc_fail <= 1'b1;
      run(OP_TAIL_RQ, 64'h3000);
      chk(status, ST_FAIL);
      repeat (2) @(posedge mclk);
      #1;
      chk({63'h0, irq}, 64'h1);
      rw(REG_EVT, 32'h7);
      sc_fail <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk({63'h0, irq}, 64'h0);
      // Longword absolute queue: header 100, entries 200 and 300
      u_mem.mem[64'h100] = 64'h200;
      u_mem.mem[64'h104] = 64'h300;
      u_mem.mem[64'h200] = 64'h300;
      u_mem.mem[64'h204] = 64'h100;
      u_mem.mem[64'h300] = 64'h100;
      u_mem.mem[64'h304] = 64'h200;
      u_mem.mem[64'h400] = 64'h300;
      delay <= 4'h0;
      run(OP_ABS_L, 64'hffff_0000_0000_0200);
      chk(entry, 64'h200);
      chk(status, ST_ONE);
      chk(m(64'h100) + m(64'h304), 64'h400);
      run(OP_ABS_LD, 64'h400);
      chk(entry, 64'h300);
      chk(status, ST_ZERO);
      run(OP_ABS_L, 64'h100);
      chk(status, ST_FAIL);
      // Quadword absolute queue: header 1000, entry 1010
      u_mem.mem[64'h1000] = 64'h1010;
      u_mem.mem[64'h1008] = 64'h1010;
      u_mem.mem[64'h1010] = 64'h1000;
      u_mem.mem[64'h1018] = 64'h1000;
      u_mem.mem[64'h2000] = 64'h1010;
      fault_addr <= 64'h1008;
      fault_code <= EXC_FOW;
      run(OP_ABS_Q, 64'h1010);
      chk({61'h0, exc_code}, {61'h0, EXC_FOW});
      chk(m(64'h1000) + m(64'h1008), 64'h2020);
      fault_addr <= '1;
      run(OP_ABS_QD, 64'h2000);
      chk(entry, 64'h1010);
      chk(status, ST_ZERO);
      chk(m(64'h1000) + m(64'h1008), 64'h2000);
      u_mem.mem[64'h1800] = 64'h1004;
      run(OP_ABS_Q, 64'h1800);
      chk({61'h0, exc_code}, {61'h0, EXC_ILL});
      run(OP_ABS_QD, 64'h2008);
      chk({61'h0, exc_code}, {61'h0, EXC_ILL});
      run(3'h5, 64'h0);
      chk({62'h0, busy, mem_lock}, 64'h0);
      chk({61'h0, exc_code}, {61'h0, EXC_ILL});
      report_and_stop;
   end
endmodule
`default_nettype wire
